// >>> design/psat_pkg.sv
// package with timing constants and state codes for the pseudo-static memory host controller
package psat_pkg;
  // clock period in picoseconds (250 MHz)
  localparam int CLK_PERIOD_PS = 4000;
  // timing figures in their own units
  localparam int MAX_SELECT_PULSE_US = 4;
  localparam int SELECT_HIGH_GAP_NS = 5;
  localparam int ADDR_TO_WRITE_END_NS = 70;
  localparam int SELECT_TO_WRITE_END_NS = 70;
  localparam int LANE_TO_WRITE_END_NS = 70;
  localparam int STROBE_HIGH_GAP_NS = 10;
  localparam int SLEEP_DWELL_MIN_US = 10;
  localparam int SLEEP_EXIT_PULSE_US = 10;
  localparam int POWERUP_WAIT_US = 150;
  localparam int READ_CYCLE_NS = 70;
  localparam int WRITE_PULSE_NS = 45;
  // minimum intervals round up, maximum intervals round down
  localparam int MAX_SELECT_CYC = (MAX_SELECT_PULSE_US * 1000000) / CLK_PERIOD_PS;
  localparam int SELECT_GAP_CYC =
    (SELECT_HIGH_GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int STROBE_GAP_CYC =
    (STROBE_HIGH_GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ADDR_WR_CYC =
    (ADDR_TO_WRITE_END_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SEL_WR_CYC =
    (SELECT_TO_WRITE_END_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int LANE_WR_CYC =
    (LANE_TO_WRITE_END_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WPULSE_CYC = (WRITE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int READ_CYC = (READ_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SLEEP_DWELL_CYC =
    (SLEEP_DWELL_MIN_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SLEEP_EXIT_CYC =
    (SLEEP_EXIT_PULSE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int POWERUP_CYC =
    (POWERUP_WAIT_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // bus and counter widths
  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;
  localparam int CNT_W = 16;
  // idle pin levels
  localparam logic [1:0] LANES_OFF = 2'h3;
  // controller states
  typedef enum logic [2:0] {
    PSAT_POWERUP = 3'b000,
    PSAT_IDLE = 3'b001,
    PSAT_WRITE = 3'b010,
    PSAT_READ = 3'b011,
    PSAT_GAP = 3'b100,
    PSAT_SLEEP = 3'b101,
    PSAT_WAKE = 3'b110
  } psat_state_t;
endpackage : psat_pkg

// >>> design/psat_timer.sv
// down counter that reports when a loaded interval has run out
`timescale 1ns/1ps
module psat_timer
  import psat_pkg::*;
(
  // clocking
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // load and status
  input wire logic load,
  input wire logic [psat_pkg::CNT_W-1:0] load_val,
  output logic done
);
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic done_reg;
  logic done_next;

  // next count: load wins, else count down to zero
  always_comb begin
    cnt_next = cnt_reg;
    if (load) begin
      cnt_next = load_val;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1;
    end
    done_next = (cnt_next == '0);
  end

  // register, frozen while the enable is low
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      done_reg <= 1'b1;
    end else if (ce) begin
      cnt_reg <= cnt_next;
      done_reg <= done_next;
    end
  end

  assign done = done_reg;
endmodule : psat_timer

// >>> design/psat_pulse_guard.sv
// counts cycles a strobe has been low and flags the approach to its ceiling
`timescale 1ns/1ps
module psat_pulse_guard
  import psat_pkg::*;
(
  // clocking
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // watched strobe and limit flag
  input wire logic strobe_low,
  output logic near_limit
);
  logic [CNT_W-1:0] len_reg;
  logic [CNT_W-1:0] len_next;

  // length grows while low, clears when high
  always_comb begin
    len_next = strobe_low ? len_reg + 1'b1 : '0;
  end

  // register, frozen with the enable
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      len_reg <= '0;
    end else if (ce) begin
      len_reg <= len_next;
    end
  end

  // two cycles of margin, since release takes one registered step
  assign near_limit = (len_reg >= CNT_W'(MAX_SELECT_CYC - 2));
endmodule : psat_pulse_guard

// >>> design/psat_host.sv
// host controller driving the strobes of the pseudo-static memory
`timescale 1ns/1ps
module psat_host
  import psat_pkg::*;
(
  // clocking
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // user request port
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [psat_pkg::ADDR_W-1:0] req_addr,
  input wire logic [psat_pkg::DATA_W-1:0] req_wdata,
  input wire logic [1:0] req_lanes,
  input wire logic sleep_req,
  input wire logic wake_req,
  output logic req_ready,
  output logic rd_valid,
  output logic [psat_pkg::DATA_W-1:0] rd_data,
  output logic in_sleep,
  // memory pins
  output logic mem_cs_n,
  output logic mem_we_n,
  output logic mem_oe_n,
  output logic mem_zz_n,
  output logic [1:0] byte_lane_selects_n,
  output logic [psat_pkg::ADDR_W-1:0] mem_addr,
  output logic [psat_pkg::DATA_W-1:0] mem_dq_o,
  output logic mem_dq_oe,
  input wire logic [psat_pkg::DATA_W-1:0] mem_dq_i
);
  import psat_pkg::*;

  psat_state_t state_reg; // current state
  psat_state_t state_next;
  logic cs_n_reg; // chip select pin
  logic cs_n_next;
  logic we_n_reg; // write strobe pin
  logic we_n_next;
  logic oe_n_reg; // output enable pin
  logic oe_n_next;
  logic zz_n_reg; // deep power-down pin, low requests sleep
  logic zz_n_next;
  logic [1:0] lanes_reg; // byte lane selects, active low
  logic [1:0] lanes_next;
  logic [ADDR_W-1:0] addr_reg; // address held for the whole access
  logic [ADDR_W-1:0] addr_next;
  logic [DATA_W-1:0] wd_reg; // write data
  logic [DATA_W-1:0] wd_next;
  logic dq_oe_reg; // data drive enable
  logic dq_oe_next;
  logic ready_reg; // accepting requests
  logic ready_next;
  logic rdv_reg; // read data pulse
  logic rdv_next;
  logic [DATA_W-1:0] rd_reg; // captured read data
  logic [DATA_W-1:0] rd_next;
  logic sleep_reg; // deep sleep state shown to user
  logic sleep_next;
  logic tm_load; // timer load strobe
  logic [CNT_W-1:0] tm_val; // timer load value
  logic tm_done; // timer has run out
  logic long_done; // long wait counter run out
  logic long_load;
  logic [CNT_W-1:0] long_val;
  logic cs_near_max; // chip select close to its ceiling
  logic we_near_max; // write strobe close to its ceiling
  logic armed_reg; // low only in the first cycle after reset
  logic armed_next;

  // short interval timer for access and gap phases
  psat_timer u_short (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .load(tm_load),
    .load_val(tm_val),
    .done(tm_done)
  );

  // long interval timer for powerup and sleep waits
  psat_timer u_long (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .load(long_load),
    .load_val(long_val),
    .done(long_done)
  );

  // watchdog on the chip select low time
  psat_pulse_guard u_cs_guard (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .strobe_low(!cs_n_reg && state_reg != PSAT_WAKE),
    .near_limit(cs_near_max)
  );

  // watchdog on the write strobe low time
  psat_pulse_guard u_we_guard (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .strobe_low(!we_n_reg),
    .near_limit(we_near_max)
  );

  // the pulse length of a single access is far below the ceiling; the guards
  // are a backstop in case the timing constants are ever lengthened
  // next-state and pin logic
  always_comb begin
    state_next = state_reg;
    cs_n_next = cs_n_reg;
    we_n_next = we_n_reg;
    oe_n_next = oe_n_reg;
    zz_n_next = zz_n_reg;
    lanes_next = lanes_reg;
    addr_next = addr_reg;
    wd_next = wd_reg;
    dq_oe_next = dq_oe_reg;
    ready_next = 1'b0;
    rdv_next = 1'b0;
    rd_next = rd_reg;
    sleep_next = sleep_reg;
    tm_load = 1'b0;
    tm_val = '0;
    long_load = 1'b0;
    long_val = '0;
    unique case (state_reg)
      PSAT_POWERUP: begin
        // hold everything idle until initialization is over
        if (!armed_reg) begin
          // the long timer comes out of reset already run out, so the full
          // wait must be loaded here or power-on would skip it
          long_load = 1'b1;
          long_val = CNT_W'(POWERUP_CYC);
        end else if (long_done) begin
          state_next = PSAT_IDLE;
          ready_next = 1'b1;
        end
      end
      PSAT_IDLE: begin
        ready_next = 1'b1;
        if (sleep_req) begin
          // enter deep sleep, dwell timer starts now
          zz_n_next = 1'b0;
          sleep_next = 1'b1;
          ready_next = 1'b0;
          long_load = 1'b1;
          long_val = CNT_W'(SLEEP_DWELL_CYC);
          state_next = PSAT_SLEEP;
        end else if (req_valid) begin
          // address, select and lanes all go out together so each is
          // qualified for the full pulse before the write ends
          addr_next = req_addr;
          lanes_next = ~req_lanes;
          cs_n_next = 1'b0;
          ready_next = 1'b0;
          tm_load = 1'b1;
          if (req_write) begin
            wd_next = req_wdata;
            dq_oe_next = 1'b1;
            we_n_next = 1'b0;
            // longest of the three write-end windows and the pulse width
            tm_val = CNT_W'(ADDR_WR_CYC > WPULSE_CYC ? ADDR_WR_CYC : WPULSE_CYC);
            state_next = PSAT_WRITE;
          end else begin
            oe_n_next = 1'b0;
            tm_val = CNT_W'(READ_CYC);
            state_next = PSAT_READ;
          end
        end
      end
      PSAT_WRITE: begin
        // the windows share one start, so one timer covers all three
        if (tm_done || we_near_max || cs_near_max) begin
          we_n_next = 1'b1;
          cs_n_next = 1'b1;
          lanes_next = LANES_OFF;
          dq_oe_next = 1'b0;
          tm_load = 1'b1;
          // gap covers both the select and strobe high times
          tm_val = CNT_W'(SELECT_GAP_CYC > STROBE_GAP_CYC ?
                          SELECT_GAP_CYC : STROBE_GAP_CYC);
          state_next = PSAT_GAP;
        end
      end
      PSAT_READ: begin
        if (tm_done || cs_near_max) begin
          rd_next = mem_dq_i;
          rdv_next = 1'b1;
          cs_n_next = 1'b1;
          oe_n_next = 1'b1;
          lanes_next = LANES_OFF;
          tm_load = 1'b1;
          tm_val = CNT_W'(SELECT_GAP_CYC);
          state_next = PSAT_GAP;
        end
      end
      PSAT_GAP: begin
        // strobes stay high until the gap has run out
        if (tm_done) begin
          state_next = PSAT_IDLE;
          ready_next = 1'b1;
        end
      end
      PSAT_SLEEP: begin
        // a wake request waits out the minimum dwell
        if (wake_req && long_done) begin
          zz_n_next = 1'b1;
          cs_n_next = 1'b0;
          long_load = 1'b1;
          long_val = CNT_W'(SLEEP_EXIT_CYC);
          state_next = PSAT_WAKE;
        end
      end
      PSAT_WAKE: begin
        // exit pulse must be long; the hidden refresh ceiling does not apply
        if (long_done) begin
          cs_n_next = 1'b1;
          sleep_next = 1'b0;
          long_load = 1'b1;
          long_val = CNT_W'(POWERUP_CYC);
          state_next = PSAT_POWERUP;
        end
      end
      default: begin
        // illegal code: raise select and strobes, drop the drive enable, and return to powerup without reloading its wait
        state_next = PSAT_POWERUP;
        cs_n_next = 1'b1;
        we_n_next = 1'b1;
        oe_n_next = 1'b1;
        dq_oe_next = 1'b0;
      end
    endcase
  end

  // state registers; the powerup wait is armed in the first cycle after reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= PSAT_POWERUP;
      cs_n_reg <= 1'b1;
      we_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      zz_n_reg <= 1'b1;
      lanes_reg <= LANES_OFF;
      addr_reg <= '0;
      wd_reg <= '0;
      dq_oe_reg <= 1'b0;
      ready_reg <= 1'b0;
      rdv_reg <= 1'b0;
      rd_reg <= '0;
      sleep_reg <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      cs_n_reg <= cs_n_next;
      we_n_reg <= we_n_next;
      oe_n_reg <= oe_n_next;
      zz_n_reg <= zz_n_next;
      lanes_reg <= lanes_next;
      addr_reg <= addr_next;
      wd_reg <= wd_next;
      dq_oe_reg <= dq_oe_next;
      ready_reg <= ready_next;
      rdv_reg <= rdv_next;
      rd_reg <= rd_next;
      sleep_reg <= sleep_next;
    end
  end

  // first cycle after reset arms the powerup wait
  always_comb begin
    armed_next = 1'b1;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      armed_reg <= 1'b0;
    end else if (ce) begin
      armed_reg <= armed_next;
    end
  end

  // outputs come straight from registers
  assign mem_cs_n = cs_n_reg;
  assign mem_we_n = we_n_reg;
  assign mem_oe_n = oe_n_reg;
  assign mem_zz_n = zz_n_reg;
  assign byte_lane_selects_n = lanes_reg;
  assign mem_addr = addr_reg;
  assign mem_dq_o = wd_reg;
  assign mem_dq_oe = dq_oe_reg;
  assign req_ready = ready_reg;
  assign rd_valid = rdv_reg;
  assign rd_data = rd_reg;
  assign in_sleep = sleep_reg;
endmodule : psat_host

// >>> bench/psat_host_monitor.sv
// pin timing checker for the memory host controller
`timescale 1ns/1ps
module psat_host_monitor
  import psat_pkg::*;
(
  // clocking
  input wire logic clk,
  input wire logic rst_n,
  // user side status
  input wire logic rd_valid,
  input wire logic in_sleep,
  // memory pins
  input wire logic mem_cs_n,
  input wire logic mem_we_n,
  input wire logic mem_oe_n,
  input wire logic mem_zz_n,
  input wire logic [1:0] byte_lane_selects_n,
  input wire logic [psat_pkg::ADDR_W-1:0] mem_addr
);
  int cs_cnt; // cycles chip select has been low
  int we_cnt; // cycles write strobe has been low
  int zz_cnt; // cycles in deep sleep
  int ad_cnt; // cycles since address last changed
  int ln_cnt; // cycles since lanes last changed
  int pu_cnt; // cycles since reset or sleep exit
  logic [ADDR_W-1:0] addr_q;
  logic [1:0] lane_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // counters restart on each change so stability is measured, not assumed
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cs_cnt <= 0;
      we_cnt <= 0;
      zz_cnt <= 0;
      ad_cnt <= 0;
      ln_cnt <= 0;
      pu_cnt <= 0;
      addr_q <= '0;
      lane_q <= LANES_OFF;
    end else begin
      cs_cnt <= mem_cs_n ? 0 : cs_cnt + 1;
      we_cnt <= mem_we_n ? 0 : we_cnt + 1;
      zz_cnt <= mem_zz_n ? 0 : zz_cnt + 1;
      ad_cnt <= (mem_addr != addr_q) ? 1 : ad_cnt + 1;
      ln_cnt <= (byte_lane_selects_n != lane_q) ? 1 : ln_cnt + 1;
      pu_cnt <= $fell(in_sleep) ? 0 : pu_cnt + 1;
      addr_q <= mem_addr;
      lane_q <= byte_lane_selects_n;
    end
  end
  // end of a write: the strobe returns high
  sequence write_end;
    $rose(mem_we_n);
  endsequence
  a_cs_low_max: assert property (!in_sleep && !mem_cs_n |-> cs_cnt < MAX_SELECT_CYC)
    else $error("chip select low too long");
  a_we_low_max: assert property (!mem_we_n |-> we_cnt < MAX_SELECT_CYC)
    else $error("write strobe low too long");
  a_cs_high_gap: assert property ($rose(mem_cs_n) |-> mem_cs_n[*2])
    else $error("chip select high gap too short");
  a_addr_before_end: assert property (write_end |-> ad_cnt >= ADDR_WR_CYC)
    else $error("address not stable before write end");
  a_sel_before_end: assert property (write_end |-> cs_cnt >= SEL_WR_CYC)
    else $error("chip select too short before write end");
  a_lane_before_end: assert property (write_end |-> ln_cnt >= LANE_WR_CYC)
    else $error("lanes not stable before write end");
  a_we_high_gap: assert property (write_end |-> mem_we_n[*3])
    else $error("write strobe high gap too short");
  a_sleep_dwell: assert property ($rose(mem_zz_n) |-> zz_cnt >= SLEEP_DWELL_CYC)
    else $error("deep sleep left too early");
  a_wake_pulse: assert property ($fell(in_sleep) |-> cs_cnt >= SLEEP_EXIT_CYC)
    else $error("wake pulse too short");
  a_init_wait: assert property ($fell(mem_cs_n) && !in_sleep |-> pu_cnt >= POWERUP_CYC)
    else $error("access before initialization");
  a_read_answer: assert property ($rose(mem_oe_n) |-> rd_valid)
    else $error("read ended without data");
endmodule : psat_host_monitor

bind psat_host psat_host_monitor u_mon (.clk(clk), .rst_n(rst_n), .rd_valid(rd_valid),
  .in_sleep(in_sleep), .mem_cs_n(mem_cs_n), .mem_we_n(mem_we_n), .mem_oe_n(mem_oe_n),
  .mem_zz_n(mem_zz_n), .byte_lane_selects_n(byte_lane_selects_n), .mem_addr(mem_addr));

// >>> bench/psat_mem_model.sv
// behavioural model of the pseudo-static memory behind the host pins
`timescale 1ns/1ps
module psat_mem_model
  import psat_pkg::*;
(
  // clocking
  input wire logic clk,
  input wire logic rst_n,
  // memory pins
  input wire logic cs_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic zz_n,
  input wire logic [1:0] lanes_n,
  input wire logic [psat_pkg::ADDR_W-1:0] addr,
  input wire logic [psat_pkg::DATA_W-1:0] wdata,
  output logic [psat_pkg::DATA_W-1:0] rdata,
  // flag: access seen before initialization ended
  output logic early
);
  logic [DATA_W-1:0] mem [16]; // small array, low address bits only
  logic [DATA_W-1:0] last; // last value driven
  int up_cnt; // initialization progress
  // undriven bus shows the inverse of its last value, never a stale match
  assign rdata = (!cs_n && !oe_n) ? mem[addr[3:0]] : ~last;
  // writes land on selected lanes; deep sleep restarts initialization
  always @(posedge clk) begin
    if (!rst_n || !zz_n) begin
      up_cnt <= 0;
      early <= !rst_n ? 1'b0 : early;
    end else begin
      if (up_cnt < POWERUP_CYC) up_cnt <= up_cnt + 1;
      if (!cs_n && (!we_n || !oe_n) && up_cnt < POWERUP_CYC) early <= 1'b1;
      if (!cs_n && !we_n && !lanes_n[0]) mem[addr[3:0]][7:0] <= wdata[7:0];
      if (!cs_n && !we_n && !lanes_n[1]) mem[addr[3:0]][15:8] <= wdata[15:8];
      last <= rdata;
    end
  end
endmodule : psat_mem_model

// >>> bench/psat_host_tb.sv
// self-checking bench for the memory host controller
`timescale 1ns/1ps
module psat_host_tb;
  import psat_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [ADDR_W-1:0] req_addr = '0;
  logic [DATA_W-1:0] req_wdata = '0;
  logic [1:0] req_lanes = 2'h0;
  logic sleep_req = 1'b0;
  logic wake_req = 1'b0;
  logic req_ready, rd_valid, in_sleep, cs_n, we_n, oe_n, zz_n, dq_oe, early;
  logic [DATA_W-1:0] rd_data, dq_o, dq_i;
  logic [ADDR_W-1:0] addr;
  logic [1:0] lanes_n;
  int n_errors = 0;
  int num_checks = 0;
  // 250 MHz clock
  always #2 clk = ~clk;
  psat_host dut (.clk(clk), .rst_n(rst_n), .ce(1'b1), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_lanes(req_lanes),
    .sleep_req(sleep_req), .wake_req(wake_req), .req_ready(req_ready), .rd_valid(rd_valid),
    .rd_data(rd_data), .in_sleep(in_sleep), .mem_cs_n(cs_n), .mem_we_n(we_n),
    .mem_oe_n(oe_n), .mem_zz_n(zz_n), .byte_lane_selects_n(lanes_n), .mem_addr(addr),
    .mem_dq_o(dq_o), .mem_dq_oe(dq_oe), .mem_dq_i(dq_i));
  psat_mem_model model (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .we_n(we_n), .oe_n(oe_n),
    .zz_n(zz_n), .lanes_n(lanes_n), .addr(addr), .wdata(dq_o), .rdata(dq_i), .early(early));
  // compare one value
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      n_errors++;
    end
  endtask : chk
  // verdict and end of run
  task automatic finish_test;
    if (n_errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test
  // pin picked by number, so one wait task serves them all
  function automatic logic pin(input int s);
    case (s)
      0: return cs_n;
      1: return zz_n;
      2: return req_ready;
      default: return in_sleep;
    endcase
  endfunction : pin
  // counts falling edges while a pin holds lvl; running out counts a mismatch
  task automatic hold(input int s, input logic lvl, input int lim, output int n);
    n = 0;
    while (pin(s) === lvl) begin
      @(negedge clk);
      n++;
      if (n > lim) begin
        n_errors++;
        finish_test();
      end
    end
  endtask : hold
  // one request held until taken, then timed at the pins
  task automatic access(input logic w, input logic [21:0] a, input logic [15:0] d,
                        input logic [1:0] l, input logic [15:0] exp);
    int n;
    int lowc;
    @(negedge clk);
    req_write = w;
    req_addr = a;
    req_wdata = d;
    req_lanes = l;
    req_valid = 1'b1;
    // ready is looked at on the falling edge, where it has settled; the
    // rising edge after a high sample takes the request
    hold(2, 1'b0, 100, n);
    @(negedge clk);
    req_valid = 1'b0;
    hold(0, 1'b1, 4, n);
    chk("strobes", {w, !w, w}, {dq_oe, we_n, oe_n});
    hold(0, 1'b0, 2000, lowc);
    chk("low time", 1, lowc >= SEL_WR_CYC && lowc < MAX_SELECT_CYC);
    if (!w) begin
      chk("rd_valid", 1, rd_valid);
      chk("rd_data", exp, rd_data);
    end
    hold(2, 1'b0, 10, n);
    chk("select gap", 1, n >= SELECT_GAP_CYC);
  endtask : access
  // pins idle while reset is held
  task automatic t_reset;
    chk("idle pins", 32'h0000_01f8, {cs_n, we_n, oe_n, zz_n, lanes_n, dq_oe, req_ready,
      in_sleep});
  endtask : t_reset
  // partial lane writes must leave the other byte alone
  task automatic t_lanes;
    access(1'b1, 22'h00_0005, 16'ha5c3, 2'h3, 16'h0000);
    access(1'b0, 22'h00_0005, 16'h0000, 2'h3, 16'ha5c3);
    access(1'b1, 22'h00_0005, 16'h1e00, 2'h2, 16'h0000);
    access(1'b0, 22'h00_0005, 16'h0000, 2'h3, 16'h1ec3);
    access(1'b1, 22'h00_0005, 16'h0077, 2'h1, 16'h0000);
    access(1'b0, 22'h00_0005, 16'h0000, 2'h3, 16'h1e77);
  endtask : t_lanes
  // wake asked at once: dwell, exit pulse and re-initialization all enforced
  task automatic t_sleep;
    int n;
    @(negedge clk);
    sleep_req = 1'b1;
    hold(3, 1'b0, 10, n);
    sleep_req = 1'b0;
    wake_req = 1'b1;
    chk("zz_n", 0, zz_n);
    hold(1, 1'b0, 3000, n);
    chk("dwell", 1, n >= SLEEP_DWELL_CYC);
    hold(0, 1'b1, 4, n);
    hold(0, 1'b0, 3000, n);
    wake_req = 1'b0;
    chk("wake pulse", 1, n >= SLEEP_EXIT_CYC);
    chk("in_sleep", 0, in_sleep);
    hold(2, 1'b0, 40000, n);
    chk("init wait", 1, n >= POWERUP_CYC);
    access(1'b1, 22'h3f_fff0, 16'h5a0f, 2'h3, 16'h0000);
    access(1'b0, 22'h3f_fff0, 16'h0000, 2'h3, 16'h5a0f);
  endtask : t_sleep
  // main sequence
  initial begin
    int n;
    repeat (12) @(negedge clk);
    t_reset();
    rst_n = 1'b1;
    hold(2, 1'b0, 40000, n);
    chk("power-on wait", 1, n >= POWERUP_CYC);
    t_lanes();
    t_sleep();
    chk("early access", 0, early);
    finish_test();
  end
endmodule : psat_host_tb
